/* File: pkg/tenbase_regs_pkg.sv */
// Constants for the 10BASE-T control/status and driver test/self-test register bank.
// Assumes a plain management port with a five-bit register address.
// Behaviour
// - Bit 7 of the control/status register holds link pulse suppression, reset zero, writable.
// - Suppression bit one stops normal link pulses; zero sends them as usual.
// - Bit 6 forces a good 10 Mb link report; zero restores normal evaluation.
// - Bit 4 is a read-only latched-high copy of the status polarity flag.
// - Reading control/status clears both polarity copies; status register reads do not.
// - Bit 1 disables heartbeat when one; acts only in half-duplex 10 Mb.
// - At 100 Mb or full duplex heartbeat stays off, disable bit ignored.
// - Bit 0 disables jabber when one; acts only in 10BASE-T operation.
// - Extension bits 15:8 count errored self-test nibbles, read-only, reset zero.
// - The nibble error count clears whenever packet self-test restarts.
// - The nibble error count saturates at its maximum instead of wrapping.
// - Extension bit 5 makes packet self-test send pseudo-random data without gaps.
// - Extension bit 4 enables the 10 Mb driver test pattern, reset zero.
// - With pattern enabled, two select bits choose one of four test patterns.
package tenbase_regs_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int CNT_W = 8;
	localparam logic [4:0] OFF_CTRL_STATUS = 5'h1A;
	localparam logic [4:0] OFF_DRV_TEST = 5'h1B;
	localparam logic [4:0] OFF_IRQ_STATUS = 5'h1E;
	localparam logic [4:0] OFF_IRQ_MASK = 5'h1F;
	// Control/status field positions.
	localparam int B_PULSE_SUPPRESS = 7;
	localparam int B_FORCE_LINK = 6;
	localparam int B_RSVD5 = 5;
	localparam int B_POLARITY = 4;
	localparam int B_RSVD3 = 3;
	localparam int B_RSVD2 = 2;
	localparam int B_SQE_OFF = 1;
	localparam int B_GUARD_OFF = 0;
	// Extension field positions.
	localparam int B_CNT_LO = 8;
	localparam int B_CONT = 5;
	localparam int B_PAT_EN = 4;
	localparam int B_PAT_GAP = 2;
	localparam int B_SEL_LO = 0;
	// Writable masks and reset values.
	localparam logic [15:0] CTRL_RW_MASK = 16'h00EF;
	localparam logic [15:0] CTRL_RESET = 16'h0004;
	localparam logic [15:0] DRV_RW_MASK = 16'h00F7;
	localparam logic [15:0] DRV_RESET = 16'h0000;
	// Interrupt event bits.
	localparam int EV_POLARITY = 0;
	localparam int EV_SATURATE = 1;
	localparam int EV_W = 2;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	typedef enum logic [1:0] {
		PAT_DATA_EOP0 = 2'h0,
		PAT_DATA_EOP1 = 2'h1,
		PAT_LINK_PULSES = 2'h2,
		PAT_MANCHESTER_ONES = 2'h3
	} pattern_e;
endpackage

/* File: hw/polarity_latch.sv */
// Latched-high capture of the inverted-polarity indication.
// Assumes the clear pulse comes from a read of the control/status register.
`timescale 1ns/100ps
module polarity_latch
(
	input wire logic clk,
	input wire logic rst,
	input wire logic inverted,
	input wire logic clear,
	output logic latched
);
	// A new detection in the clearing cycle survives the clear.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			latched <= 1'b0;
		else if (inverted)
			latched <= 1'b1;
		else if (clear)
			latched <= 1'b0;
	end
endmodule // polarity_latch

/* File: hw/nibble_err_counter.sv */
// Saturating counter of errored self-test nibbles.
// Assumes error and restart are one-cycle pulses in the clock domain.
`timescale 1ns/100ps
module nibble_err_counter
(
	input wire logic clk,
	input wire logic rst,
	input wire logic restart,
	input wire logic nibble_err,
	output logic [tenbase_regs_pkg::CNT_W-1:0] count,
	output logic saturate_pulse
);
	import tenbase_regs_pkg::*;
	logic [CNT_W-1:0] next_count;
	wire at_max = (count == CNT_MAX);
	// Restart wins over a counted error; the count holds at its top value.
	assign next_count = restart ? CNT_ZERO
		: (nibble_err && !at_max) ? count + 8'h01 : count;
	assign saturate_pulse = nibble_err && !restart && (count == CNT_MAX - 8'h01);
	// Counter storage.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			count <= CNT_ZERO;
		else
			count <= next_count;
	end
endmodule // nibble_err_counter

/* File: hw/tenbase_t_ctrl_selftest_regs.sv */
// Register bank for 10BASE-T control/status and the driver test/self-test extension.
// Assumes one-cycle read and write strobes, never together, with read data a cycle later.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module tenbase_t_ctrl_selftest_regs
	import tenbase_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [tenbase_regs_pkg::ADDR_W-1:0] addr,
	input wire logic [tenbase_regs_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [tenbase_regs_pkg::DATA_W-1:0] rdata,
	input wire logic pol_inverted,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic selftest_restart,
	input wire logic selftest_nibble_err,
	output logic phy_status_polarity,
	output logic normal_pulse_suppress,
	output logic link_pulse_enable,
	output logic force_link_good,
	output logic sqe_test_enable,
	output logic long_tx_guard_enable,
	output logic selftest_continuous,
	output logic driver_pattern_enable,
	output logic [1:0] driver_pattern_select,
	output logic driver_pattern_gap_long,
	output logic irq
);
	import tenbase_regs_pkg::*;

	// Address match used by every decode below.
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	logic [DATA_W-1:0] ctrl;
	logic [DATA_W-1:0] drv;
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_mask;
	logic [EV_W-1:0] next_irq_status;
	logic [DATA_W-1:0] next_rdata;
	logic pol_latched;
	logic [CNT_W-1:0] err_count;
	logic sat_pulse;
	logic pol_prev;

	// Named decodes of the register port.
	wire sel_ctrl = hit(addr, OFF_CTRL_STATUS);
	wire sel_drv = hit(addr, OFF_DRV_TEST);
	wire sel_ist = hit(addr, OFF_IRQ_STATUS);
	wire sel_imask = hit(addr, OFF_IRQ_MASK);
	wire wr_ctrl = wr && sel_ctrl;
	wire wr_drv = wr && sel_drv;
	wire wr_ist = wr && sel_ist;
	wire wr_imask = wr && sel_imask;
	wire rd_ctrl = rd && sel_ctrl;
	wire ten_mb = !speed_100;
	wire half_10 = ten_mb && !full_duplex;

	// Polarity flag shared by this register and the PHY status register.
	polarity_latch u_pol
	(
		.clk(clk),
		.rst(rst),
		.inverted(pol_inverted),
		.clear(rd_ctrl),
		.latched(pol_latched)
	);

	// Self-test nibble error counter.
	nibble_err_counter u_cnt
	(
		.clk(clk),
		.rst(rst),
		.restart(selftest_restart),
		.nibble_err(selftest_nibble_err),
		.count(err_count),
		.saturate_pulse(sat_pulse)
	);

	// Writable bits only; read-only positions keep their reset zero.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl <= CTRL_RESET;
			drv <= DRV_RESET;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= wdata & CTRL_RW_MASK;
			if (wr_drv)
				drv <= wdata & DRV_RW_MASK;
		end
	end

	// Read mux: live fields, unmapped addresses read zero.
	always_comb
	begin
		next_rdata = 16'h0000;
		if (sel_ctrl)
		begin
			next_rdata = ctrl;
			next_rdata[B_POLARITY] = pol_latched;
		end
		else if (sel_drv)
		begin
			next_rdata = drv;
			next_rdata[B_CNT_LO +: CNT_W] = err_count;
		end
		else if (sel_ist)
			next_rdata = {14'h0000, irq_status};
		else if (sel_imask)
			next_rdata = {14'h0000, irq_mask};
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= 16'h0000;
		else if (rd)
			rdata <= next_rdata;
		else
			rdata <= 16'h0000;
	end

	// Events: new polarity inversion and counter reaching its top; set beats clear.
	assign next_irq_status = (irq_status & ~(wr_ist ? wdata[EV_W-1:0] : 2'h0))
		| {sat_pulse, pol_inverted && !pol_prev};
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			irq_status <= 2'h0;
			irq_mask <= IRQ_MASK_RESET;
			pol_prev <= 1'b0;
		end
		else
		begin
			irq_status <= next_irq_status;
			pol_prev <= pol_inverted;
			if (wr_imask)
				irq_mask <= wdata[EV_W-1:0];
		end
	end
	assign irq = |(irq_status & irq_mask);

	// Control outputs steered by the stored fields.
	assign phy_status_polarity = pol_latched;
	assign normal_pulse_suppress = ctrl[B_PULSE_SUPPRESS];
	assign link_pulse_enable = !ctrl[B_PULSE_SUPPRESS];
	assign force_link_good = ctrl[B_FORCE_LINK];
	assign sqe_test_enable = half_10 && !ctrl[B_SQE_OFF];
	assign long_tx_guard_enable = ten_mb && !ctrl[B_GUARD_OFF];
	assign selftest_continuous = drv[B_CONT];
	assign driver_pattern_enable = drv[B_PAT_EN];
	assign driver_pattern_select = drv[B_SEL_LO +: 2];
	assign driver_pattern_gap_long = drv[B_PAT_GAP];
endmodule // tenbase_t_ctrl_selftest_regs

/* File: verification/tenbase_regs_properties.sv */
// Port checker for the 10BASE-T register bank.
// Assumes the bind below wires it to every same-named port of the bank.
`timescale 1ns/100ps
module tenbase_regs_checker
	import tenbase_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic pol_inverted,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic phy_status_polarity,
	input wire logic normal_pulse_suppress,
	input wire logic link_pulse_enable,
	input wire logic force_link_good,
	input wire logic sqe_test_enable,
	input wire logic long_tx_guard_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Each property ties an output to its cause: a register port cycle, a PHY input or a related output.
	property p_lpe; link_pulse_enable == !normal_pulse_suppress; endproperty
	a_lpe: assert property (p_lpe) else $error("pulse enable wrong");
	property p_nps; wr && addr == 5'h1A |=> normal_pulse_suppress == $past(wdata[7]); endproperty
	a_nps: assert property (p_nps) else $error("suppress bit lost");
	property p_flg; wr && addr == 5'h1A |=> force_link_good == $past(wdata[6]); endproperty
	a_flg: assert property (p_flg) else $error("force link lost");
	property p_sqe; speed_100 || full_duplex |-> !sqe_test_enable; endproperty
	a_sqe: assert property (p_sqe) else $error("heartbeat on");
	property p_grd; speed_100 |-> !long_tx_guard_enable; endproperty
	a_grd: assert property (p_grd) else $error("jabber on");
	property p_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("stray read data");
	property p_set; pol_inverted |=> phy_status_polarity; endproperty
	a_set: assert property (p_set) else $error("polarity not latched");
	property p_clr; rd && addr == 5'h1A && !pol_inverted |=> !phy_status_polarity; endproperty
	a_clr: assert property (p_clr) else $error("polarity not cleared");
	property p_rd4; rd && addr == 5'h1A |=> rdata[4] == $past(phy_status_polarity); endproperty
	a_rd4: assert property (p_rd4) else $error("polarity read wrong");
endmodule // tenbase_regs_checker

bind tenbase_t_ctrl_selftest_regs tenbase_regs_checker i_chk (.*);

/* File: verification/tenbase_t_ctrl_selftest_regs_bench.sv */
// Self-checking bench for the 10BASE-T register bank.
// Assumes the bank and its checker are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h want %h", $time, g, e); end end
module tenbase_t_ctrl_selftest_regs_bench;
	import tenbase_regs_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, pol_inverted = 0, speed_100 = 0, full_duplex = 0;
	logic selftest_restart = 0, selftest_nibble_err = 0;
	logic [4:0] addr = 0;
	logic [15:0] wdata = 0, rdata;
	logic phy_status_polarity, normal_pulse_suppress, link_pulse_enable, force_link_good;
	logic sqe_test_enable, long_tx_guard_enable, selftest_continuous, driver_pattern_enable;
	logic driver_pattern_gap_long, irq;
	logic [1:0] driver_pattern_select;
	int errors = 0, n_checks = 0, cyc = 0;
	tenbase_t_ctrl_selftest_regs i_dut (.*);
	// Clock and hang guard.
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		if (++cyc == 2000)
		begin
			errors++;
			results();
		end
	end
	// Register port cycles: one strobe cycle, read data checked in the next.
	task automatic wreg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk) wr <= 0;
	endtask
	task automatic rchk(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk) {rd, addr} <= {1'b1, a};
		@(posedge clk) rd <= 0;
		#1 `CHK(rdata, e)
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence of tests.
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 0;
		rchk(5'h1A, 16'h0004);
		rchk(5'h1B, 16'h0000);
		rchk(5'h05, 16'h0000);
		`CHK(link_pulse_enable, 1'b1)
		$display("reset test done");
		wreg(5'h1A, 16'h00C7);
		#1 `CHK({normal_pulse_suppress, link_pulse_enable, force_link_good}, 3'b101)
		`CHK({sqe_test_enable, long_tx_guard_enable}, 2'b00)
		rchk(5'h1A, 16'h00C7);
		wreg(5'h1A, 16'h0004);
		#1 `CHK({sqe_test_enable, long_tx_guard_enable, force_link_good}, 3'b110)
		@(posedge clk) full_duplex <= 1;
		#1 `CHK({sqe_test_enable, long_tx_guard_enable}, 2'b01)
		@(posedge clk) {full_duplex, speed_100} <= 2'b01;
		#1 `CHK({sqe_test_enable, long_tx_guard_enable}, 2'b00)
		@(posedge clk) speed_100 <= 0;
		$display("control test done");
		wreg(5'h1F, 16'h0003);
		@(posedge clk) pol_inverted <= 1;
		@(posedge clk) pol_inverted <= 0;
		rchk(5'h1E, 16'h0001);
		`CHK({phy_status_polarity, irq}, 2'b11)
		rchk(5'h1A, 16'h0014);
		rchk(5'h1A, 16'h0004);
		wreg(5'h1E, 16'h0001);
		#1 `CHK({phy_status_polarity, irq}, 2'b00)
		$display("polarity test done");
		@(posedge clk) selftest_nibble_err <= 1;
		repeat (3) @(posedge clk);
		selftest_nibble_err <= 0;
		wreg(5'h1A, 16'h0005);
		#1 `CHK(long_tx_guard_enable, 1'b0)
		wreg(5'h1B, 16'hFF37);
		rchk(5'h1B, 16'h0337);
		`CHK({selftest_continuous, driver_pattern_enable, driver_pattern_gap_long}, 3'b111)
		@(posedge clk) selftest_restart <= 1;
		@(posedge clk) selftest_restart <= 0;
		rchk(5'h1B, 16'h0037);
		@(posedge clk) selftest_nibble_err <= 1;
		repeat (300) @(posedge clk);
		selftest_nibble_err <= 0;
		rchk(5'h1B, 16'hFF37);
		rchk(5'h1E, 16'h0002);
		`CHK(irq, 1'b1)
		for (int i = 0; i < 4; i++)
		begin
			wreg(5'h1B, {14'h0004, i[1:0]});
			#1 `CHK({driver_pattern_enable, driver_pattern_select}, {1'b1, i[1:0]})
		end
		$display("self-test test done");
		results();
	end
endmodule // tenbase_t_ctrl_selftest_regs_bench
